// ### hdl/pbseq_pkg.sv
package pbseq_pkg;

	// =====================================================
	// Timing
	// =====================================================
	localparam int unsigned CLK_HZ          = 20000000;
	localparam int unsigned DEBOUNCE_MS     = 32;
	localparam int unsigned DEBOUNCE_CYC    = CLK_HZ / 1000 * DEBOUNCE_MS;
	localparam int unsigned LONG_PUSH_MS    = 8000;
	localparam int unsigned LONG_PUSH_CYC   = CLK_HZ / 1000 * LONG_PUSH_MS;
	localparam int unsigned CONFIRM_MS      = 300;
	localparam int unsigned CONFIRM_CYC     = CLK_HZ / 1000 * CONFIRM_MS;
	localparam int unsigned RESET_PULSE_MS  = 10;
	localparam int unsigned RESET_PULSE_CYC = CLK_HZ / 1000 * RESET_PULSE_MS;
	localparam int unsigned CNT_W           = 32;

	// =====================================================
	// Idle level and reset values
	// =====================================================
	localparam logic        BTN_IDLE        = 1'b1;
	localparam logic        OUT_OFF_N       = 1'b1;

	// =====================================================
	// States and status bits
	// =====================================================
	typedef enum logic [1:0] {
		PBSEQ_OFF     = 2'b00,
		PBSEQ_START   = 2'b01,
		PBSEQ_RUN     = 2'b10,
		PBSEQ_LP_RST  = 2'b11
	} pbseq_state_e;

	typedef struct packed {
		logic shutdown_req_n;
		logic low_battery_n;
		logic button_state_n;
	} pbseq_status_s;

endpackage : pbseq_pkg

// ### hdl/pbseq_top.sv
`timescale 1ns/10ps
// How it works
// - Forced button acts on falling edge after power-up
// - Off: single button press powers up
// - Running: single button press requests shutdown
// - Long hold of both buttons powers down or resets regardless
// - Low battery flagged on low startup press
// - Low battery flagged on undervoltage while enabled
// - Press asserts enable immediately
// - Confirm high during startup keeps enable
// - Every power press asserts shutdown request
// - Confirm low while running drops enable
// - Undervoltage while running asserts shutdown request
// - Button state follows press, not undervoltage
// - Variant samples confirm after button release
// - Press counts after debounce low period
// - Unconfirmed startup drops enable
module pbseq_top #(
	parameter int unsigned DEBOUNCE_CYC    = pbseq_pkg::DEBOUNCE_CYC,
	parameter int unsigned LONG_PUSH_CYC   = pbseq_pkg::LONG_PUSH_CYC,
	parameter int unsigned CONFIRM_CYC     = pbseq_pkg::CONFIRM_CYC,
	parameter int unsigned RESET_PULSE_CYC = pbseq_pkg::RESET_PULSE_CYC,
	parameter bit          EN_ACTIVE_HIGH  = 1'b1,
	parameter bit          LONG_PUSH_RESET = 1'b0,
	parameter bit          WAIT_RELEASE    = 1'b1
) (
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic power_button_in,
	input  wire logic forced_action_button_in,
	input  wire logic power_confirm_in,
	input  wire logic supply_above_startup,
	input  wire logic supply_undervoltage,
	output logic      enable_out,
	output logic      shutdown_req_n_out,
	output logic      low_battery_n_out,
	output logic      button_state_n_out,
	output logic      app_reset_n_out
);

	// =====================================================
	// Debounce
	// =====================================================
	logic [pbseq_pkg::CNT_W-1:0] pb_cnt_ff;
	logic [pbseq_pkg::CNT_W-1:0] fa_cnt_ff;
	logic                        pb_prs_ff;
	logic                        fa_prs_ff;
	logic                        fa_prs_d_ff;
	logic                        fa_armed_ff;
	pbseq_pkg::pbseq_state_e      state_ff;

	// Any high sample restarts the count, so short low pulses never register
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pb_cnt_ff <= '0;
			pb_prs_ff <= 1'b0;
		end
		else if (power_button_in == pbseq_pkg::BTN_IDLE)
		begin
			pb_cnt_ff <= '0;
			pb_prs_ff <= 1'b0;
		end
		else if (pb_cnt_ff < pbseq_pkg::CNT_W'(DEBOUNCE_CYC - 1))
			pb_cnt_ff <= pb_cnt_ff + 1'b1;
		else
			pb_prs_ff <= 1'b1;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fa_cnt_ff <= '0;
			fa_prs_ff <= 1'b0;
		end
		else if (forced_action_button_in == pbseq_pkg::BTN_IDLE)
		begin
			fa_cnt_ff <= '0;
			fa_prs_ff <= 1'b0;
		end
		else if (fa_cnt_ff < pbseq_pkg::CNT_W'(DEBOUNCE_CYC - 1))
			fa_cnt_ff <= fa_cnt_ff + 1'b1;
		else
			fa_prs_ff <= 1'b1;
	end

	// Forced button armed only by a fresh falling edge after power-up
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fa_prs_d_ff <= 1'b0;
			fa_armed_ff <= 1'b0;
		end
		else
		begin
			fa_prs_d_ff <= fa_prs_ff;
			if (state_ff != pbseq_pkg::PBSEQ_RUN || !fa_prs_ff)
				fa_armed_ff <= 1'b0;
			else if (fa_prs_ff && !fa_prs_d_ff)
				fa_armed_ff <= 1'b1;
		end
	end

	// =====================================================
	// Sequencer
	// =====================================================
	pbseq_pkg::pbseq_state_e      nxt_state;
	logic [pbseq_pkg::CNT_W-1:0] tmr_ff;
	logic [pbseq_pkg::CNT_W-1:0] lp_cnt_ff;
	logic                        pb_prs_d_ff;
	logic                        en_ff;
	logic                        nxt_en;
	logic                        pb_rise;
	logic                        long_push;
	logic                        confirm_ok;

	assign pb_rise   = pb_prs_ff && !pb_prs_d_ff;
	assign long_push = lp_cnt_ff == pbseq_pkg::CNT_W'(LONG_PUSH_CYC - 1);
	// Release-wait variant ignores confirm while the button is still down
	assign confirm_ok = power_confirm_in && (!WAIT_RELEASE || !pb_prs_ff);

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			lp_cnt_ff <= '0;
		else if (state_ff != pbseq_pkg::PBSEQ_RUN || !pb_prs_ff || !fa_armed_ff)
			lp_cnt_ff <= '0;
		else if (!long_push)
			lp_cnt_ff <= lp_cnt_ff + 1'b1;
	end

	always_comb
	begin
		nxt_state = state_ff;
		nxt_en    = en_ff;
		unique case (state_ff)
			pbseq_pkg::PBSEQ_OFF:
				if (pb_rise && supply_above_startup)
				begin
					nxt_state = pbseq_pkg::PBSEQ_START;
					nxt_en    = 1'b1;
				end
			pbseq_pkg::PBSEQ_START:
				if (supply_undervoltage)
				begin
					nxt_state = pbseq_pkg::PBSEQ_OFF;
					nxt_en    = 1'b0;
				end
				else if (confirm_ok)
					nxt_state = pbseq_pkg::PBSEQ_RUN;
				else if (WAIT_RELEASE && !pb_prs_ff && !power_confirm_in)
				begin
					nxt_state = pbseq_pkg::PBSEQ_OFF;
					nxt_en    = 1'b0;
				end
				else if (tmr_ff == pbseq_pkg::CNT_W'(CONFIRM_CYC - 1))
				begin
					nxt_state = pbseq_pkg::PBSEQ_OFF;
					nxt_en    = 1'b0;
				end
			pbseq_pkg::PBSEQ_RUN:
				if (!power_confirm_in || supply_undervoltage)
				begin
					nxt_state = pbseq_pkg::PBSEQ_OFF;
					nxt_en    = 1'b0;
				end
				else if (long_push && LONG_PUSH_RESET)
					nxt_state = pbseq_pkg::PBSEQ_LP_RST;
				else if (long_push)
				begin
					nxt_state = pbseq_pkg::PBSEQ_OFF;
					nxt_en    = 1'b0;
				end
			pbseq_pkg::PBSEQ_LP_RST:
				if (tmr_ff == pbseq_pkg::CNT_W'(RESET_PULSE_CYC - 1))
					nxt_state = pbseq_pkg::PBSEQ_START;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff    <= pbseq_pkg::PBSEQ_OFF;
			en_ff       <= 1'b0;
			pb_prs_d_ff <= 1'b0;
		end
		else
		begin
			state_ff    <= nxt_state;
			en_ff       <= nxt_en;
			pb_prs_d_ff <= pb_prs_ff;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			tmr_ff <= '0;
		else if (nxt_state != state_ff)
			tmr_ff <= '0;
		else
			tmr_ff <= tmr_ff + 1'b1;
	end

	// =====================================================
	// Outputs
	// =====================================================
	pbseq_pkg::pbseq_status_s nxt_st;
	pbseq_pkg::pbseq_status_s st_ff;

	always_comb
	begin
		nxt_st.button_state_n = !pb_prs_ff;
		// Press is reported at every stage, off or on
		nxt_st.shutdown_req_n = !(pb_prs_ff ||
			(state_ff == pbseq_pkg::PBSEQ_RUN && supply_undervoltage));
		nxt_st.low_battery_n  = !((pb_prs_ff && !en_ff && !supply_above_startup) ||
			(en_ff && supply_undervoltage));
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_ff           <= '{pbseq_pkg::OUT_OFF_N, pbseq_pkg::OUT_OFF_N,
				pbseq_pkg::OUT_OFF_N};
			enable_out      <= !EN_ACTIVE_HIGH;
			app_reset_n_out <= 1'b0;
		end
		else
		begin
			st_ff           <= nxt_st;
			enable_out      <= nxt_en ~^ EN_ACTIVE_HIGH;
			app_reset_n_out <= nxt_state == pbseq_pkg::PBSEQ_RUN;
		end
	end

	assign shutdown_req_n_out = st_ff.shutdown_req_n;
	assign low_battery_n_out  = st_ff.low_battery_n;
	assign button_state_n_out = st_ff.button_state_n;

	// =====================================================
	// Checks
	// =====================================================
	a_press_enables: assert property (@(posedge core_clk) disable iff (!rst_n)
		state_ff == pbseq_pkg::PBSEQ_OFF && pb_rise && supply_above_startup
		|=> state_ff == pbseq_pkg::PBSEQ_START && en_ff)
		else $error("Press did not enable");
	a_confirm_low_drop: assert property (@(posedge core_clk) disable iff (!rst_n)
		state_ff == pbseq_pkg::PBSEQ_RUN && !power_confirm_in |=> !en_ff)
		else $error("Confirm low kept enable");
	a_press_request: assert property (@(posedge core_clk) disable iff (!rst_n)
		pb_prs_ff |=> !shutdown_req_n_out)
		else $error("Press gave no shutdown request");
	a_uv_no_button: assert property (@(posedge core_clk) disable iff (!rst_n)
		!pb_prs_ff |=> button_state_n_out)
		else $error("Button state without press");
	a_uv_low_batt: assert property (@(posedge core_clk) disable iff (!rst_n)
		en_ff && supply_undervoltage |=> !low_battery_n_out)
		else $error("Undervoltage not flagged");
	// Own count, so the check does not lean on the sequencer timer
	logic [pbseq_pkg::CNT_W-1:0] chk_start_cnt_ff;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			chk_start_cnt_ff <= '0;
		else if (state_ff != pbseq_pkg::PBSEQ_START)
			chk_start_cnt_ff <= '0;
		else
			chk_start_cnt_ff <= chk_start_cnt_ff + 1'b1;
	end

	a_start_timeout: assert property (@(posedge core_clk) disable iff (!rst_n)
		chk_start_cnt_ff < pbseq_pkg::CNT_W'(CONFIRM_CYC))
		else $error("Startup never resolved");
	a_debounce_min: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(pb_prs_ff) |-> pb_cnt_ff == pbseq_pkg::CNT_W'(DEBOUNCE_CYC - 1))
		else $error("Press before debounce");
	a_en_polarity: assert property (@(posedge core_clk) disable iff (!rst_n)
		enable_out == ((state_ff != pbseq_pkg::PBSEQ_OFF) ~^ EN_ACTIVE_HIGH))
		else $error("Enable polarity wrong");
	a_uv_request: assert property (@(posedge core_clk) disable iff (!rst_n)
		state_ff == pbseq_pkg::PBSEQ_RUN && supply_undervoltage |=> !shutdown_req_n_out)
		else $error("Undervoltage gave no request");
	a_low_start_batt: assert property (@(posedge core_clk) disable iff (!rst_n)
		pb_prs_ff && !en_ff && !supply_above_startup |=> !low_battery_n_out)
		else $error("Low startup supply not flagged");
	a_press_btn_state: assert property (@(posedge core_clk) disable iff (!rst_n)
		pb_prs_ff |=> !button_state_n_out)
		else $error("Press not shown on button state");
	a_fa_fresh_edge: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(fa_armed_ff) |-> $past(fa_prs_ff) && !$past(fa_prs_d_ff)
		&& $past(state_ff) == pbseq_pkg::PBSEQ_RUN)
		else $error("Forced button armed without fresh edge");
	a_lp_reset_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
		state_ff == pbseq_pkg::PBSEQ_LP_RST |-> !app_reset_n_out && en_ff)
		else $error("Long push reset pulse wrong");

endmodule : pbseq_top

// ### tb/pbseq_partner.sv
`timescale 1ns/10ps
module pbseq_partner #(
	parameter bit EN_ACTIVE_HIGH = 1'b1
) (
	input  wire logic       pb_press,
	input  wire logic       fa_press,
	input  wire logic [1:0] confirm_mode,
	input  wire logic       enable_out,
	input  wire logic       shutdown_req_n_out,
	input  wire logic       button_state_n_out,
	output logic            power_button_in,
	output logic            forced_action_button_in,
	output logic            power_confirm_in
);
	// =====================================
	// Buttons
	// =====================================
	// Open-drain pull-down over a pull-up: idle is high, never stuck low
	assign power_button_in         = pb_press ? 1'b0 : 1'b1;
	assign forced_action_button_in = fa_press ? 1'b0 : 1'b1;
	// =====================================
	// Processor confirm
	// =====================================
	// 0 never confirms, 1 tied to rail, 2 tied to request, 3 tied to button state
	always_comb
	begin
		case (confirm_mode)
			2'h1:    power_confirm_in = enable_out ~^ EN_ACTIVE_HIGH;
			2'h2:    power_confirm_in = shutdown_req_n_out;
			2'h3:    power_confirm_in = button_state_n_out;
			default: power_confirm_in = 1'b0;
		endcase
	end
endmodule : pbseq_partner

// ### tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	localparam int DEB = 4;
	localparam int LP  = 20;
	logic       core_clk = 1'b0;
	logic       rst_n    = 1'b0;
	logic       pb       = 1'b0;
	logic       fa       = 1'b0;
	logic [1:0] mode     = 2'h1;
	logic       sup_ok   = 1'b1;
	logic       uv       = 1'b0;
	logic       pbi, fai, conf, en, sreq_n, lowb_n, btn_n, arst_n;
	logic       pb_b     = 1'b0;
	logic       fa_b     = 1'b0;
	logic [1:0] mode_b   = 2'h1;
	logic       pbi_b, fai_b, conf_b, en_b, sreq_b, lowb_b, btn_b, arst_b;
	pbseq_pkg::pbseq_status_s st;
	int         n_fail     = 0;
	int         num_checks = 0;
	assign st = '{shutdown_req_n: sreq_n, low_battery_n: lowb_n, button_state_n: btn_n};
	always #25 core_clk = ~core_clk;
	pbseq_top #(.DEBOUNCE_CYC(DEB), .LONG_PUSH_CYC(LP), .CONFIRM_CYC(30),
		.RESET_PULSE_CYC(5)) dut (.core_clk(core_clk), .rst_n(rst_n),
		.power_button_in(pbi), .forced_action_button_in(fai), .power_confirm_in(conf),
		.supply_above_startup(sup_ok), .supply_undervoltage(uv), .enable_out(en),
		.shutdown_req_n_out(sreq_n), .low_battery_n_out(lowb_n),
		.button_state_n_out(btn_n), .app_reset_n_out(arst_n));
	pbseq_partner far (.pb_press(pb), .fa_press(fa), .confirm_mode(mode), .enable_out(en),
		.shutdown_req_n_out(sreq_n), .button_state_n_out(btn_n), .power_button_in(pbi),
		.forced_action_button_in(fai), .power_confirm_in(conf));
	// Second unit covers the other build options
	pbseq_top #(.DEBOUNCE_CYC(DEB), .LONG_PUSH_CYC(LP), .CONFIRM_CYC(30),
		.RESET_PULSE_CYC(5), .EN_ACTIVE_HIGH(1'b0), .LONG_PUSH_RESET(1'b1),
		.WAIT_RELEASE(1'b0)) dut_alt (.core_clk(core_clk), .rst_n(rst_n),
		.power_button_in(pbi_b), .forced_action_button_in(fai_b), .power_confirm_in(conf_b),
		.supply_above_startup(sup_ok), .supply_undervoltage(uv), .enable_out(en_b),
		.shutdown_req_n_out(sreq_b), .low_battery_n_out(lowb_b),
		.button_state_n_out(btn_b), .app_reset_n_out(arst_b));
	pbseq_partner #(.EN_ACTIVE_HIGH(1'b0)) far_alt (.pb_press(pb_b), .fa_press(fa_b),
		.confirm_mode(mode_b), .enable_out(en_b), .shutdown_req_n_out(sreq_b),
		.button_state_n_out(btn_b), .power_button_in(pbi_b),
		.forced_action_button_in(fai_b), .power_confirm_in(conf_b));
	// =====================================
	// Helpers
	// =====================================
	task automatic summarize;
		if (n_fail == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize
	task automatic chk(input logic [2:0] seen, input logic [2:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask : cyc
	// Bounded wait for enable; timeout counts and ends the run
	task automatic wait_en(input logic v, input int bound);
		int i;
		for (i = 0; i < bound && en !== v; i++)
			cyc(1);
		chk({2'h0, en}, {2'h0, v});
		if (en !== v)
			summarize();
	endtask : wait_en
	// Press, hold a random while, release, then look at enable
	task automatic power_up(input logic exp);
		pb = 1'b1;
		wait_en(1'b1, DEB + 4);
		chk(st, 3'h2);
		cyc($urandom_range(1, 10));
		pb = 1'b0;
		cyc(4);
		chk({1'b0, en, arst_n}, {1'b0, exp, exp});
	endtask : power_up
	// =====================================
	// Scenarios
	// =====================================
	initial
	begin
		void'($urandom(10));
		cyc(5);
		rst_n = 1'b1;
		cyc(2);
		pb = 1'b1;
		cyc($urandom_range(1, DEB - 1));
		pb = 1'b0;
		cyc(6);
		chk({2'h0, en}, 3'h0);
		sup_ok = 1'b0;
		pb = 1'b1;
		cyc(DEB + 4);
		chk({lowb_n, en, 1'b0}, 3'h0);
		pb = 1'b0;
		sup_ok = 1'b1;
		cyc(6);
		power_up(1'b1);
		uv = 1'b1;
		cyc(1);
		chk(st, 3'h1);
		wait_en(1'b0, 4);
		uv = 1'b0;
		mode = 2'h0;
		cyc(6);
		power_up(1'b0);
		mode = 2'h1;
		cyc(6);
		power_up(1'b1);
		mode = 2'h0;
		wait_en(1'b0, 4);
		mode = 2'h1;
		cyc(6);
		power_up(1'b1);
		mode = 2'h2;
		pb = 1'b1;
		fa = 1'b1;
		wait_en(1'b0, DEB + 6);
		pb = 1'b0;
		fa = 1'b0;
		mode = 2'h1;
		cyc(6);
		power_up(1'b1);
		pb = 1'b1;
		fa = 1'b1;
		cyc(LP - 2);
		chk({2'h0, en}, 3'h1);
		wait_en(1'b0, DEB + 10);
		// Release-wait unit never starts with confirm tied to button state
		pb = 1'b0;
		fa = 1'b0;
		mode = 2'h3;
		cyc(6);
		power_up(1'b0);
		// Second unit: active-low enable, long push resets, no release wait
		chk({lowb_b, 1'b0, en_b}, 3'h5);
		mode_b = 2'h3;
		pb_b = 1'b1;
		cyc(DEB + 4);
		chk({btn_b, en_b, arst_b}, 3'h0);
		pb_b = 1'b0;
		cyc(4);
		chk({1'b0, en_b, arst_b}, 3'h1);
		pb_b = 1'b1;
		cyc(DEB + 4);
		chk({sreq_b, en_b, arst_b}, 3'h2);
		pb_b = 1'b0;
		mode_b = 2'h1;
		cyc(6);
		pb_b = 1'b1;
		cyc(DEB + 4);
		chk({1'b0, en_b, arst_b}, 3'h1);
		fa_b = 1'b1;
		cyc(LP + DEB + 3);
		chk({1'b0, en_b, arst_b}, 3'h0);
		cyc(6);
		chk({1'b0, en_b, arst_b}, 3'h1);
		cyc(LP + 4);
		chk({1'b0, en_b, arst_b}, 3'h1);
		summarize();
	end
endmodule : tb_top
